// ---- include/link_responder_defines.vh ----
`ifndef LINK_RESPONDER_DEFINES_VH
`define LINK_RESPONDER_DEFINES_VH

// transaction codes
`define TCODE_WRITE_QUADLET 4'h0
`define TCODE_READ_QUADLET  4'h4
`define TCODE_READ_RESPONSE 4'h6

// acknowledge codes
`define ACK_COMPLETE   4'h1
`define ACK_PENDING    4'h2
`define ACK_TYPE_ERROR 4'hE

// response codes
`define RCODE_COMPLETE   4'h0
`define RCODE_TYPE_ERROR 4'h6

// retry field of every generated response
`define RETRY_X 2'h1

// identifiers
`define PHY_ID_BROADCAST 6'h3F
`define BUS_ID_LOCAL     10'h3FF

// max_rec field: one quadlet of payload
`define MAX_REC 4'h1

// packet lengths in quadlets, header crc included
`define LEN_WRITE_QUADLET 3'h5
`define LEN_READ_QUADLET  3'h4
`define CRC_POS_READ      3'h3
`define CRC_POS_OTHER     3'h4
`define RESPONSE_LAST     3'h4

// header field positions in the first quadlet
`define HDR_BUS_MSB   31
`define HDR_BUS_LSB   22
`define HDR_PHY_MSB   21
`define HDR_PHY_LSB   16
`define HDR_TL_MSB    15
`define HDR_TL_LSB    10
`define HDR_TCODE_MSB 7
`define HDR_TCODE_LSB 4

// address map, all in the node register space
`define OFFSET_HIGH    16'hFFFF
`define ADDR_CONTROL   32'hF000_0800
`define ADDR_ROM_BASE  32'hF000_0400
`define ROM_INDEX_MASK 32'hFFFF_FFF3

// header crc
`define CRC_POLY 32'h04C1_1DB7
`define CRC_INIT 32'hFFFF_FFFF

// reset value of the writable control register
`define CONTROL_RESET 32'h0000_0000

`endif

// ---- hdl/header_crc.v ----
`timescale 1ns/1ps
`default_nettype none
`include "link_responder_defines.vh"

module header_crc (
  input  wire        mclk,
  input  wire        reset_n,
  input  wire        clear,
  input  wire        enable,
  input  wire [31:0] data,
  output reg  [31:0] crc
);

  reg [31:0] next_crc;
  integer    i;

  // one quadlet per cycle, most significant bit first
  always @* begin
    next_crc = crc;
    for (i = 31; i >= 0; i = i - 1) begin
      if (next_crc[31] ^ data[i])
        next_crc = {next_crc[30:0], 1'b0} ^ `CRC_POLY;
      else
        next_crc = {next_crc[30:0], 1'b0};
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      crc <= `CRC_INIT;
    end else if (clear) begin
      crc <= `CRC_INIT;
    end else if (enable) begin
      crc <= next_crc;
    end
  end

endmodule

`default_nettype wire

// ---- hdl/two_entry_buffer.v ----
`timescale 1ns/1ps
`default_nettype none

module two_entry_buffer #(
  parameter WIDTH = 33
) (
  input  wire             mclk,
  input  wire             reset_n,
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] spare;
  reg             spare_full;

  wire take = in_valid && in_ready;
  wire give = out_valid && out_ready;

  // second slot catches a word while the receiver stalls, so ready can stay registered
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid  <= 1'b0;
      out_data   <= {WIDTH{1'b0}};
      spare      <= {WIDTH{1'b0}};
      spare_full <= 1'b0;
      in_ready   <= 1'b1;
    end else begin
      if (give || !out_valid) begin
        if (spare_full) begin
          out_data   <= spare;
          out_valid  <= 1'b1;
          spare_full <= take;
          if (take)
            spare <= in_data;
        end else begin
          out_data  <= in_data;
          out_valid <= take;
        end
        in_ready <= 1'b1;
      end else if (take) begin
        spare      <= in_data;
        spare_full <= 1'b1;
        in_ready   <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ---- hdl/quadlet_link_responder.v ----
// What this block does
// - asynchronous transactions only, isochronous ignored
// - no split-transaction timeout register or logic
// - reads concatenated response, writes answered by ack
// - two request kinds in, one packet out
// - bad header crc: drop silently, no effects
// - only the header crc is checked
// - max_rec fixed at one quadlet
// - tcode 0 quadlet write, 4 quadlet read
// - block transactions not recognised
// - bus broadcast write accepted on own bus
// - local-bus broadcast write accepted
// - broadcast writes never acknowledged
// - other tcodes to us get type error
// - configuration rom in general format
// - only packet sent: read response tcode 6
// - ack 1 write, 2 read, E otherwise
// - response code 0 complete, 6 type error
// - never retry, rt is retry_X
`timescale 1ns/1ps
`default_nettype none
`include "link_responder_defines.vh"

module quadlet_link_responder #(
  parameter [31:0] ROM_HEADER  = 32'h0404_0000,
  parameter [31:0] ROM_NAME    = 32'h3133_3934, // arbitrary value
  parameter [31:0] ROM_VENDOR  = 32'h0012_3400, // arbitrary value
  parameter [31:0] ROM_ROOTDIR = 32'h0000_0000
) (
  input  wire        mclk,
  input  wire        reset_n,
  input  wire [15:0] node_id,
  input  wire        rx_valid,
  input  wire        rx_last,
  input  wire [31:0] rx_data,
  input  wire        tx_ready,
  output wire        tx_valid,
  output wire [31:0] tx_data,
  output wire        tx_last,
  output reg         ack_valid,
  output reg  [7:0]  ack_data,
  output reg  [31:0] user_control
);

  localparam [1:0] S_RX     = 2'b00;
  localparam [1:0] S_DECIDE = 2'b01;
  localparam [1:0] S_RESP   = 2'b10;

  // every phy input pin passes two flops; word strobe and data stay in step
  reg  [34:0] sync_first;
  reg  [34:0] sync_second;
  wire        in_valid = sync_second[34];
  wire        in_last  = sync_second[33];
  wire [31:0] in_data  = sync_second[32:1];
  wire        out_ready_pin = sync_second[0];

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync_first  <= {35{1'b0}};
      sync_second <= {35{1'b0}};
    end else begin
      sync_first  <= {rx_valid, rx_last, rx_data, tx_ready};
      sync_second <= sync_first;
    end
  end

  reg [1:0]  state;
  reg [2:0]  word_cnt;
  reg [31:0] hdr0;
  reg [31:0] hdr1;
  reg [31:0] off_lo;
  reg [31:0] quad3;
  reg        crc_ok;
  reg [2:0]  rsp_cnt;
  reg [31:0] read_data;
  reg [3:0]  rcode;
  wire       buf_in_ready;

  wire [3:0] tcode  = hdr0[`HDR_TCODE_MSB:`HDR_TCODE_LSB];
  wire [9:0] dst_bus = hdr0[`HDR_BUS_MSB:`HDR_BUS_LSB];
  wire [5:0] dst_phy = hdr0[`HDR_PHY_MSB:`HDR_PHY_LSB];

  // only the header crc position matters; data crc is never examined
  wire [2:0] crc_pos = (tcode == `TCODE_READ_QUADLET) ? `CRC_POS_READ : `CRC_POS_OTHER;
  wire       rx_word = in_valid && (state == S_RX);

  wire [31:0] rx_crc;
  header_crc rx_checker (
    .mclk    (mclk),
    .reset_n (reset_n),
    .clear   (state != S_RX),
    .enable  (rx_word && (word_cnt == 3'h0 || word_cnt < crc_pos)),
    .data    (in_data),
    .crc     (rx_crc)
  );

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      word_cnt <= 3'h0;
      hdr0     <= 32'h0000_0000;
      hdr1     <= 32'h0000_0000;
      off_lo   <= 32'h0000_0000;
      quad3    <= 32'h0000_0000;
      crc_ok   <= 1'b0;
    end else if (state != S_RX) begin
      word_cnt <= 3'h0;
      crc_ok   <= 1'b0;
    end else if (rx_word) begin
      case (word_cnt)
        3'h0: hdr0 <= in_data;
        3'h1: hdr1 <= in_data;
        3'h2: off_lo <= in_data;
        3'h3: quad3 <= in_data;
        default: ;
      endcase
      if (word_cnt != 3'h0 && word_cnt == crc_pos)
        crc_ok <= (in_data == ~rx_crc);
      if (word_cnt != 3'h7)
        word_cnt <= word_cnt + 3'h1;
    end
  end

  // word count as it stands after the final word of the packet
  reg [2:0] pkt_len;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      pkt_len <= 3'h0;
    else if (rx_word && in_last)
      pkt_len <= (word_cnt == 3'h7) ? 3'h7 : word_cnt + 3'h1;
  end

  // address decode: control word, four-quadlet rom
  wire addr_high_ok = (hdr1[15:0] == `OFFSET_HIGH);
  wire is_control   = addr_high_ok && (off_lo == `ADDR_CONTROL);
  wire is_rom       = addr_high_ok && ((off_lo & `ROM_INDEX_MASK) == `ADDR_ROM_BASE);
  wire [1:0] rom_index = off_lo[3:2];

  reg [31:0] rom_word;
  always @* begin
    case (rom_index)
      2'h0: rom_word = ROM_HEADER;
      2'h1: rom_word = ROM_NAME;
      2'h2: rom_word = {16'h0000, `MAX_REC, 12'h000};
      default: rom_word = ROM_VENDOR ^ ROM_ROOTDIR;
    endcase
  end

  // decision on a complete packet
  wire is_bcast   = (dst_phy == `PHY_ID_BROADCAST);
  wire bcast_ours = (dst_bus == `BUS_ID_LOCAL) || (dst_bus == node_id[15:6]);
  wire to_us      = !is_bcast && (hdr0[31:16] == node_id);
  wire is_write   = (tcode == `TCODE_WRITE_QUADLET) && (pkt_len == `LEN_WRITE_QUADLET);
  wire is_read    = (tcode == `TCODE_READ_QUADLET) && (pkt_len == `LEN_READ_QUADLET);

  reg       do_write;
  reg       do_ack;
  reg [3:0] ack_code;
  reg       do_read;

  always @* begin
    do_write = 1'b0;
    do_ack   = 1'b0;
    ack_code = `ACK_TYPE_ERROR;
    do_read  = 1'b0;
    if (crc_ok) begin
      if (is_bcast) begin
        do_write = bcast_ours && is_write && is_control;
      end else if (to_us) begin
        do_ack = 1'b1;
        if (is_write && is_control) begin
          do_write = 1'b1;
          ack_code = `ACK_COMPLETE;
        end else if (is_read) begin
          do_read  = 1'b1;
          ack_code = `ACK_PENDING;
        end else begin
          ack_code = `ACK_TYPE_ERROR;
        end
      end
    end
  end

  // control state machine; isochronous and split handling do not exist here
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_RX;
    end else begin
      case (state)
        S_RX:
          if (rx_word && in_last)
            state <= S_DECIDE;
        S_DECIDE:
          state <= do_read ? S_RESP : S_RX;
        S_RESP:
          if (buf_in_ready && rsp_cnt == `RESPONSE_LAST)
            state <= S_RX;
        default:
          state <= S_RX;
      endcase
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ack_valid    <= 1'b0;
      ack_data     <= 8'h00;
      user_control <= `CONTROL_RESET;
      read_data    <= 32'h0000_0000;
      rcode        <= `RCODE_COMPLETE;
    end else begin
      ack_valid <= (state == S_DECIDE) && do_ack;
      if (state == S_DECIDE && do_ack)
        ack_data <= {ack_code, ~ack_code};
      if (state == S_DECIDE && do_write)
        user_control <= quad3;
      if (state == S_DECIDE && do_read) begin
        read_data <= is_control ? user_control : (is_rom ? rom_word : 32'h0000_0000);
        rcode     <= (is_control || is_rom) ? `RCODE_COMPLETE : `RCODE_TYPE_ERROR;
      end
    end
  end

  // response: five quadlets, crc last, through the buffer
  wire        push = (state == S_RESP) && buf_in_ready;
  wire [31:0] tx_crc;
  reg  [31:0] rsp_word;

  always @* begin
    case (rsp_cnt)
      3'h0: rsp_word = {hdr1[31:16], hdr0[`HDR_TL_MSB:`HDR_TL_LSB], `RETRY_X, `TCODE_READ_RESPONSE, 4'h0};
      3'h1: rsp_word = {node_id, rcode, 12'h000};
      3'h2: rsp_word = 32'h0000_0000;
      3'h3: rsp_word = read_data;
      default: rsp_word = ~tx_crc;
    endcase
  end

  header_crc tx_generator (
    .mclk    (mclk),
    .reset_n (reset_n),
    .clear   (state != S_RESP),
    .enable  (push && rsp_cnt != `RESPONSE_LAST),
    .data    (rsp_word),
    .crc     (tx_crc)
  );

  // the response is queued exactly once; nothing re-sends it
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      rsp_cnt <= 3'h0;
    else if (state != S_RESP)
      rsp_cnt <= 3'h0;
    else if (push)
      rsp_cnt <= rsp_cnt + 3'h1;
  end

  two_entry_buffer #(
    .WIDTH (33)
  ) tx_buffer (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (state == S_RESP),
    .in_ready  (buf_in_ready),
    .in_data   ({rsp_cnt == `RESPONSE_LAST, rsp_word}),
    .out_valid (tx_valid),
    .out_ready (out_ready_pin),
    .out_data  ({tx_last, tx_data})
  );

endmodule

`default_nettype wire

// ---- tb/link_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module link_monitor (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        rx_valid,
  input wire logic        rx_last,
  input wire logic        tx_ready,
  input wire logic        tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic        tx_last,
  input wire logic        ack_valid,
  input wire logic [7:0]  ack_data
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  property p_code;
    ack_valid |-> ack_data inside {8'h1e, 8'h2d, 8'he1};
  endproperty
  a_code: assert property (p_code) else $error("ack code outside set");
  property p_pulse;
    ack_valid |=> !ack_valid [*3];
  endproperty
  a_pulse: assert property (p_pulse) else $error("ack not a single pulse");
  property p_head;
    $rose(tx_valid) |-> tx_data[7:4] == 4'h6 && tx_data[9:8] == 2'b01;
  endproperty
  a_head: assert property (p_head) else $error("response head wrong");
  property p_last;
    tx_last |-> tx_valid;
  endproperty
  a_last: assert property (p_last) else $error("last without valid");
  property p_concat;
    ack_valid && ack_data == 8'h2d |-> ##[1:4] tx_valid;
  endproperty
  a_concat: assert property (p_concat) else $error("response late");
  property p_only;
    $rose(tx_valid) |-> ack_data == 8'h2d;
  endproperty
  a_only: assert property (p_only) else $error("response without read ack");
  // ready reaches the buffer two edges late, so a low ready then must pin the word
  property p_stall;
    tx_valid && !$past(tx_ready, 2) |=> tx_valid && $stable(tx_data);
  endproperty
  a_stall: assert property (p_stall) else $error("word lost in stall");
  property p_cause;
    ack_valid |-> ($past(rx_valid, 4) && $past(rx_last, 4)) || ($past(rx_valid, 5) && $past(rx_last, 5))
      || ($past(rx_valid, 6) && $past(rx_last, 6));
  endproperty
  a_cause: assert property (p_cause) else $error("ack without packet");
  c_read: cover property (ack_valid && ack_data == 8'h2d);
  c_write: cover property (ack_valid && ack_data == 8'h1e);
  c_err: cover property (ack_valid && ack_data == 8'he1);
endmodule
bind quadlet_link_responder link_monitor u_link_monitor (
  .mclk(mclk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_last(rx_last), .tx_ready(tx_ready),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .ack_valid(ack_valid), .ack_data(ack_data));
`default_nettype wire

// ---- tb/phy_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module phy_model (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        slow,
  input  wire logic        tx_valid,
  input  wire logic [31:0] tx_data,
  input  wire logic        tx_last,
  output var  logic        tx_ready
);
  logic [1:0]  sync;
  logic [1:0]  tick;
  logic [31:0] words [0:63];
  int          count;
  int          last_at;
  // mirrors the responder's two-flop ready path to know which word was taken
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync <= 2'b00;
      tick <= 2'b00;
      tx_ready <= 1'b0;
      count <= 0;
      last_at <= 0;
    end else begin
      tick <= tick + 2'b01;
      tx_ready <= !slow || tick == 2'b00;
      sync <= {sync[0], tx_ready};
      if (tx_valid && sync[1]) begin
        words[count[5:0]] <= tx_data;
        count <= count + 1;
        if (tx_last) begin
          last_at <= count + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [15:0] me = 16'h0485;
  localparam logic [31:0] ctl = 32'hf000_0800;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        slow = 1'b0;
  logic [15:0] node_id = me;
  logic        rx_valid = 1'b0;
  logic        rx_last = 1'b0;
  logic [31:0] rx_data = 32'h0000_0000;
  wire         tx_ready;
  wire         tx_valid;
  wire         tx_last;
  wire         ack_valid;
  wire  [31:0] tx_data;
  wire  [31:0] user_control;
  wire  [7:0]  ack_data;
  logic [7:0]  last_ack = 8'h00;
  logic [31:0] q3;
  int          fails = 0;
  int          checks_done = 0;
  int          acks = 0;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (ack_valid) begin
      acks <= acks + 1;
      last_ack <= ack_data;
    end
  end
  quadlet_link_responder u_quadlet_link_responder (.mclk(mclk), .reset_n(reset_n), .node_id(node_id),
    .rx_valid(rx_valid), .rx_last(rx_last), .rx_data(rx_data), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .ack_valid(ack_valid), .ack_data(ack_data),
    .user_control(user_control));
  phy_model u_phy_model (.mclk(mclk), .reset_n(reset_n), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [31:0] hcrc(input logic [31:0] w [0:4], input int n);
    logic [31:0] c;
    c = 32'hffff_ffff;
    for (int i = 0; i < n; i++)
      for (int b = 31; b >= 0; b--)
        c = (c << 1) ^ ((c[31] ^ w[i][b]) ? 32'h04c1_1db7 : 32'h0000_0000);
    return ~c;
  endfunction
  // ack of 8'h00 means none is allowed
  task automatic xfer(input logic [15:0] dst, input logic [3:0] tc, input logic [31:0] lo,
                      input logic [31:0] d, input logic bad, input logic [7:0] ack);
    logic [31:0] w [0:4];
    int n;
    int a0;
    a0 = acks;
    n = (tc == 4'h4) ? 3 : 4;
    w[0] = {dst, 6'h09, 2'b00, tc, 4'h0};
    w[1] = {16'h0123, 16'hffff};
    w[2] = lo;
    w[3] = d;
    w[n] = hcrc(w, n) ^ {31'h0, bad};
    for (int i = 0; i <= n; i++) begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_last <= (i == n);
      rx_data <= w[i];
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    repeat (10) @(posedge mclk);
    chk("ack count", {31'h0, ack != 8'h00}, acks - a0);
    if (ack != 8'h00) chk("ack code", ack, last_ack);
  endtask
  task automatic t_read(input logic [31:0] lo, input logic [3:0] rc, input logic [31:0] d, input logic full);
    logic [31:0] e [0:4];
    int c0;
    int k;
    c0 = u_phy_model.count;
    xfer(me, 4'h4, lo, 32'h0000_0000, 1'b0, 8'h2d);
    for (k = 0; k < 400 && u_phy_model.count < c0 + 5; k++) @(posedge mclk);
    e[0] = {16'h0123, 6'h09, 2'b01, 4'h6, 4'h0};
    e[1] = {me, rc, 12'h000};
    e[2] = 32'h0000_0000;
    e[3] = d;
    e[4] = hcrc(e, 4);
    for (int i = 0; i < 5; i++)
      if (full || i < 3) chk("resp word", e[i], u_phy_model.words[c0 + i]);
    chk("resp last", c0 + 5, u_phy_model.last_at);
    q3 = u_phy_model.words[c0 + 3];
  endtask
  task automatic t_write;
    xfer(me, 4'h0, ctl, 32'hcafe_0001, 1'b0, 8'h1e);
    chk("control", 32'hcafe_0001, user_control);
    xfer(me, 4'h0, ctl, 32'h1111_2222, 1'b1, 8'h00);
    xfer(16'h0486, 4'h0, ctl, 32'h3333_4444, 1'b0, 8'h00);
    chk("control", 32'hcafe_0001, user_control);
  endtask
  task automatic t_bcast;
    xfer(16'h04bf, 4'h0, ctl, 32'h0000_00b1, 1'b0, 8'h00);
    chk("control", 32'h0000_00b1, user_control);
    xfer(16'h04ff, 4'h0, ctl, 32'h0000_00b2, 1'b0, 8'h00);
    chk("control", 32'h0000_00b1, user_control);
    xfer(16'hffff, 4'h0, ctl, 32'h0000_00b3, 1'b0, 8'h00);
    chk("control", 32'h0000_00b3, user_control);
  endtask
  task automatic t_types;
    for (int t = 1; t < 16; t++)
      if (t != 4) xfer(me, t[3:0], ctl, 32'h0000_0000, 1'b0, 8'he1);
    xfer(me, 4'h0, 32'hf000_0400, 32'h5555_aaaa, 1'b0, 8'he1);
    chk("control", 32'h0000_00b3, user_control);
  endtask
  task automatic t_reads;
    t_read(ctl, 4'h0, 32'h0000_00b3, 1'b1);
    @(posedge mclk);
    slow <= 1'b1;
    t_read(ctl, 4'h0, 32'h0000_00b3, 1'b1);
    t_read(32'hf000_0408, 4'h0, 32'h0000_1000, 1'b1);
    chk("max_rec", 32'h0000_0001, {28'h0, q3[15:12]});
    t_read(32'hf000_0900, 4'h6, 32'h0000_0000, 1'b1);
  endtask
  task automatic print_verdict;
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_write;
    t_bcast;
    t_types;
    t_reads;
    print_verdict;
  end
  initial begin
    #1000000;
    fails++;
    print_verdict;
  end
endmodule
`default_nettype wire
